// file: hw/cdhp_regs.vh
// Register map, field positions, reset values and timing of the display port host
`ifndef CDHP_REGS_VH
`define CDHP_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses on the APB side)
// ----------------------------------------------------------------------------
`define CDHP_OFF_CTRL   8'h00
`define CDHP_OFF_WDATA  8'h04
`define CDHP_OFF_STAT   8'h08
`define CDHP_OFF_RDATA  8'h0C
`define CDHP_OFF_ISTAT  8'h10
`define CDHP_OFF_IMASK  8'h14

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CDHP_CTRL_START     0
`define CDHP_CTRL_RS        1
`define CDHP_CTRL_RNW       2
`define CDHP_CTRL_NIB       3
`define CDHP_STAT_ACTIVE    0
`define CDHP_STAT_BF        8
`define CDHP_STAT_AC_LSB    16
`define CDHP_IRQ_DONE       0
`define CDHP_IRQ_REFUSED    1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CDHP_CTRL_RST   4'h0
`define CDHP_WDATA_RST  8'h00
`define CDHP_IRQ_RST    2'h0
`define CDHP_PIN_RST    8'h00

// ----------------------------------------------------------------------------
// Bus timing in ns, and derived cycle counts at the system clock rate
// ----------------------------------------------------------------------------
`define CDHP_CLK_NS     10
`define CDHP_T_SU_NS    40
`define CDHP_T_PW_NS    230
`define CDHP_T_H_NS     10
`define CDHP_T_C_NS     500
`define CDHP_SU_CYC  ((`CDHP_T_SU_NS + `CDHP_CLK_NS - 1) / `CDHP_CLK_NS)
`define CDHP_PW_CYC  ((`CDHP_T_PW_NS + `CDHP_CLK_NS - 1) / `CDHP_CLK_NS)
`define CDHP_H_CYC   ((`CDHP_T_H_NS + `CDHP_CLK_NS - 1) / `CDHP_CLK_NS)
`define CDHP_LOW_CYC \
    ((`CDHP_T_C_NS - `CDHP_T_PW_NS + `CDHP_CLK_NS - 1) / `CDHP_CLK_NS)
`define CDHP_GAP_CYC (`CDHP_LOW_CYC - `CDHP_H_CYC - `CDHP_SU_CYC)

`endif

// file: hw/cdhp_ctrl.v
// Host controller that drives a character display parallel port from APB
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "cdhp_regs.vh"
module cdhp_ctrl
(
    // Clock, reset, enable
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        ce,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Interrupt
    output wire        irq,
    // Display port pins
    output wire        register_select_line,
    output wire        rw_select_line,
    output wire        enable_strobe,
    input  wire [7:0]  data_line_in,
    output wire [7:0]  data_line_out,
    output wire [7:0]  data_line_oe
);

    // ------------------------------------------------------------------------
    // State encoding
    // ------------------------------------------------------------------------
    localparam [4:0] S_IDLE  = 5'b00001;
    localparam [4:0] S_SETUP = 5'b00010;
    localparam [4:0] S_HIGH  = 5'b00100;
    localparam [4:0] S_HOLD  = 5'b01000;
    localparam [4:0] S_GAP   = 5'b10000;

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    reg [4:0]  state_r;      // Strobe sequencer state
    reg [5:0]  cnt_r;        // Cycles left in current phase
    reg        cfg_rs_r;     // Requested register select
    reg        cfg_rnw_r;    // Requested direction
    reg        cfg_nib_r;    // Nibble bus mode
    reg [7:0]  wdata_r;      // Byte to write
    reg        poll_r;       // Busy poll in progress
    reg        second_r;     // Second nibble of a byte
    reg [7:0]  rd_byte_r;    // Byte assembled from the bus
    reg [7:0]  rdata_r;      // Last completed read byte
    reg        last_bf_r;    // Busy flag from last status read
    reg [6:0]  last_ac_r;    // Address counter from last status read
    reg        done_set_r;   // Transfer finished pulse
    reg [1:0]  int_stat_r;   // Sticky interrupt status
    reg [1:0]  int_mask_r;   // Interrupt enables
    reg        irq_r;        // Interrupt output
    reg [31:0] prdata_r;     // APB read data
    reg        pready_r;     // APB ready
    reg        pslverr_r;    // APB error
    reg        rs_r;         // Register select pin
    reg        rw_r;         // Direction pin
    reg        e_r;          // Enable strobe pin
    reg [7:0]  db_out_r;     // Data pins driven
    reg [7:0]  db_oe_r;      // Data pin enables

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Phase length to counter load value
    function [5:0] cyc;
        input integer n;
        integer       t;
        begin
            t   = n - 1;
            cyc = t[5:0];
        end
    endfunction

    // Byte or nibble placed on the data lines
    function [7:0] bus_byte;
        input [7:0] b;
        input       nib;
        input       sec;
        begin
            if (!nib)
                bus_byte = b;
            else if (!sec)
                bus_byte = {b[7:4], 4'h0};
            else
                bus_byte = {b[3:0], 4'h0};
        end
    endfunction

    // Merge sampled lines into the byte being read
    function [7:0] merge_rd;
        input [7:0] old;
        input [7:0] pins;
        input       nib;
        input       sec;
        begin
            if (!nib)
                merge_rd = pins;
            else if (!sec)
                merge_rd = {pins[7:4], old[3:0]};
            else
                merge_rd = {old[7:4], pins[7:4]};
        end
    endfunction

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    wire apb_setup = psel & ~penable;
    wire apb_do    = psel & penable & pready_r;
    wire apb_wr    = apb_do & pwrite;
    wire idle      = (state_r == S_IDLE);
    wire start_req = apb_wr & (paddr == `CDHP_OFF_CTRL)
                   & pwdata[`CDHP_CTRL_START];
    wire start_ok  = start_req & idle;
    wire refused   = start_req & ~idle;
    wire is_status = ~pwdata[`CDHP_CTRL_RS] & pwdata[`CDHP_CTRL_RNW];
    wire [1:0] int_clr = (apb_wr & (paddr == `CDHP_OFF_ISTAT))
                       ? pwdata[1:0] : 2'h0;
    wire [1:0] int_set = {refused, done_set_r};
    // Set wins over a clear in the same cycle
    wire [1:0] int_stat_nxt = (int_stat_r & ~int_clr) | int_set;

    // Mapped address check
    wire addr_ok = (paddr == `CDHP_OFF_CTRL)  | (paddr == `CDHP_OFF_WDATA) |
                   (paddr == `CDHP_OFF_STAT)  | (paddr == `CDHP_OFF_RDATA) |
                   (paddr == `CDHP_OFF_ISTAT) | (paddr == `CDHP_OFF_IMASK);

    // ------------------------------------------------------------------------
    // APB slave: answer prepared in setup, ready in access
    // ------------------------------------------------------------------------
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            prdata_r   <= 32'h0000_0000;
            pready_r   <= 1'b0;
            pslverr_r  <= 1'b0;
            wdata_r    <= `CDHP_WDATA_RST;
            int_stat_r <= `CDHP_IRQ_RST;
            int_mask_r <= `CDHP_IRQ_RST;
            irq_r      <= 1'b0;
        end
        else if (ce)
        begin
            pready_r   <= apb_setup;
            pslverr_r  <= apb_setup & ~addr_ok;
            int_stat_r <= int_stat_nxt;
            irq_r      <= |(int_stat_r & int_mask_r);
            // Read data mux
            prdata_r <= 32'h0000_0000;
            if (apb_setup)
            begin
                case (paddr)
                    `CDHP_OFF_CTRL:
                        prdata_r[3:1] <= {cfg_nib_r, cfg_rnw_r, cfg_rs_r};
                    `CDHP_OFF_WDATA:
                        prdata_r[7:0] <= wdata_r;
                    `CDHP_OFF_STAT:
                    begin
                        prdata_r[`CDHP_STAT_ACTIVE] <= ~idle;
                        prdata_r[`CDHP_STAT_BF]     <= last_bf_r;
                        prdata_r[`CDHP_STAT_AC_LSB+6:`CDHP_STAT_AC_LSB]
                            <= last_ac_r;
                    end
                    `CDHP_OFF_RDATA:
                        prdata_r[7:0] <= rdata_r;
                    `CDHP_OFF_ISTAT:
                        prdata_r[1:0] <= int_stat_r;
                    `CDHP_OFF_IMASK:
                        prdata_r[1:0] <= int_mask_r;
                    default:
                        prdata_r <= 32'h0000_0000;
                endcase
            end
            // Register writes
            if (apb_wr && paddr == `CDHP_OFF_WDATA && idle)
                wdata_r <= pwdata[7:0];
            if (apb_wr && paddr == `CDHP_OFF_IMASK)
                int_mask_r <= pwdata[1:0];
        end
    end

    // ------------------------------------------------------------------------
    // Enter setup phase: place select, direction and data on the pins
    // ------------------------------------------------------------------------
    task go_setup;
        input rs;
        input rw;
        input sec;
        begin
            state_r  <= S_SETUP;
            cnt_r    <= cyc(`CDHP_SU_CYC);
            second_r <= sec;
            rs_r     <= rs;
            rw_r     <= rw;
            db_out_r <= rw ? 8'h00 : bus_byte(wdata_r, cfg_nib_r, sec);
            // Lower lines stay released in nibble mode
            db_oe_r  <= rw ? 8'h00 : (cfg_nib_r ? 8'hF0 : 8'hFF);
        end
    endtask

    // ------------------------------------------------------------------------
    // Strobe sequencer
    // ------------------------------------------------------------------------
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_r    <= S_IDLE;
            cnt_r      <= 6'h00;
            cfg_rs_r   <= 1'b0;
            cfg_rnw_r  <= 1'b0;
            cfg_nib_r  <= 1'b0;
            poll_r     <= 1'b0;
            second_r   <= 1'b0;
            rd_byte_r  <= `CDHP_PIN_RST;
            rdata_r    <= `CDHP_PIN_RST;
            last_bf_r  <= 1'b0;
            last_ac_r  <= 7'h00;
            done_set_r <= 1'b0;
            rs_r       <= 1'b0;
            rw_r       <= 1'b0;
            e_r        <= 1'b0;
            db_out_r   <= `CDHP_PIN_RST;
            db_oe_r    <= `CDHP_PIN_RST;
        end
        else if (ce)
        begin
            done_set_r <= 1'b0;
            case (state_r)
                // Wait for an order; all but status reads poll first
                S_IDLE:
                begin
                    if (start_ok)
                    begin
                        cfg_rs_r  <= pwdata[`CDHP_CTRL_RS];
                        cfg_rnw_r <= pwdata[`CDHP_CTRL_RNW];
                        cfg_nib_r <= pwdata[`CDHP_CTRL_NIB];
                        poll_r    <= ~is_status;
                        go_setup(1'b0, 1'b1, 1'b0);
                    end
                end
                // Select and direction settle before the strobe
                S_SETUP:
                begin
                    if (cnt_r == 6'h00)
                    begin
                        state_r <= S_HIGH;
                        cnt_r   <= cyc(`CDHP_PW_CYC);
                        e_r     <= 1'b1;
                    end
                    else
                        cnt_r <= cnt_r - 6'h01;
                end
                // Strobe high; read lines sampled at its end
                S_HIGH:
                begin
                    if (cnt_r == 6'h00)
                    begin
                        state_r <= S_HOLD;
                        cnt_r   <= cyc(`CDHP_H_CYC);
                        e_r     <= 1'b0;
                        if (rw_r)
                            rd_byte_r <= merge_rd(rd_byte_r, data_line_in,
                                                  cfg_nib_r, second_r);
                    end
                    else
                        cnt_r <= cnt_r - 6'h01;
                end
                // Hold pins after the falling edge, then release data
                S_HOLD:
                begin
                    if (cnt_r == 6'h00)
                    begin
                        state_r <= S_GAP;
                        cnt_r   <= cyc(`CDHP_GAP_CYC);
                        db_oe_r <= 8'h00;
                    end
                    else
                        cnt_r <= cnt_r - 6'h01;
                end
                // Low time that completes the strobe cycle
                S_GAP:
                begin
                    if (cnt_r != 6'h00)
                        cnt_r <= cnt_r - 6'h01;
                    else if (cfg_nib_r && !second_r)
                        go_setup(rs_r, rw_r, 1'b1);
                    else
                    begin
                        // Status byte: busy on top line, counter below
                        if (!rs_r && rw_r)
                        begin
                            last_bf_r <= rd_byte_r[7];
                            last_ac_r <= rd_byte_r[6:0];
                        end
                        if (poll_r)
                        begin
                            // Keep polling while the device is busy
                            if (rd_byte_r[7])
                                go_setup(1'b0, 1'b1, 1'b0);
                            else
                            begin
                                poll_r <= 1'b0;
                                go_setup(cfg_rs_r, cfg_rnw_r, 1'b0);
                            end
                        end
                        else
                        begin
                            state_r    <= S_IDLE;
                            done_set_r <= 1'b1;
                            if (rw_r)
                                rdata_r <= rd_byte_r;
                        end
                    end
                end
                default:
                    state_r <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Outputs straight from flip-flops
    // ------------------------------------------------------------------------
    assign prdata               = prdata_r;
    assign pready               = pready_r;
    assign pslverr              = pslverr_r;
    assign irq                  = irq_r;
    assign register_select_line = rs_r;
    assign rw_select_line       = rw_r;
    assign enable_strobe        = e_r;
    assign data_line_out        = db_out_r;
    assign data_line_oe         = db_oe_r;

endmodule

// file: verif/cdhp_ctrl_asserts.sv
// Port checker for the display port host controller
`timescale 1ns/1ps
`include "cdhp_regs.vh"
module cdhp_ctrl_asserts
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Display pins
    input wire logic        register_select_line,
    input wire logic        rw_select_line,
    input wire logic        enable_strobe,
    input wire logic [7:0]  data_line_in,
    input wire logic [7:0]  data_line_out,
    input wire logic [7:0]  data_line_oe
);
    // ------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------
    logic [7:0] hi_cnt;     // Strobe high cycles
    logic [7:0] lo_cnt;     // Strobe low cycles, saturating
    logic       nib_r;      // Nibble mode of the last order
    logic       ph_r;       // Second half of a nibble pair
    logic       ok_r;       // Last busy poll read idle
    // Track strobe lengths, mode, half and busy poll result
    always @(posedge clk_sys or posedge rst)
        if (rst)
        begin
            hi_cnt <= 8'h00;
            lo_cnt <= 8'hFF;
            nib_r  <= 1'b0;
            ph_r   <= 1'b0;
            ok_r   <= 1'b0;
        end
        else
        begin
            hi_cnt <= enable_strobe ? hi_cnt + 8'h01 : 8'h00;
            lo_cnt <= (enable_strobe) ? 8'h00 :
                      (lo_cnt == 8'hFF) ? lo_cnt : lo_cnt + 8'h01;
            if (psel && penable && pready && pwrite
                && paddr == `CDHP_OFF_CTRL)
                nib_r <= pwdata[`CDHP_CTRL_NIB];
            if ($fell(enable_strobe))
                ph_r <= nib_r & ~ph_r;
            // Busy flag is on the top line in the first half only
            if (enable_strobe && !register_select_line
                && rw_select_line && !ph_r)
                ok_r <= ~data_line_in[7];
            else if ($fell(enable_strobe) && !rw_select_line
                     && (ph_r || !nib_r))
                ok_r <= 1'b0;
        end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_sel_stable: assert property (
        enable_strobe |-> $stable(register_select_line)
        && $stable(rw_select_line)) else $error("select moved in strobe");
    a_sel_setup: assert property (
        $rose(enable_strobe) |->
        $past(register_select_line, 4) == register_select_line
        && $past(rw_select_line, 4) == rw_select_line)
        else $error("select setup too short");
    a_strobe_width: assert property (
        $fell(enable_strobe) |-> hi_cnt == 8'd23)
        else $error("strobe width wrong");
    a_write_hold: assert property (
        $fell(enable_strobe) && !rw_select_line |->
        data_line_oe != 8'h00 && $stable(data_line_out))
        else $error("write data not held past fall");
    a_read_release: assert property (
        enable_strobe && rw_select_line |-> data_line_oe == 8'h00)
        else $error("host drives during read");
    a_full_lanes: assert property (
        !nib_r && enable_strobe && !rw_select_line |->
        data_line_oe == 8'hFF) else $error("full width lanes wrong");
    a_nib_lanes: assert property (
        nib_r |-> (data_line_oe & 8'h0F) == 8'h00)
        else $error("low lines driven in nibble mode");
    a_cycle_gap: assert property (
        $rose(enable_strobe) |-> lo_cnt >= 8'd27)
        else $error("strobe low time too short");
    a_busy_first: assert property (
        $rose(enable_strobe) && !rw_select_line && !ph_r |-> ok_r)
        else $error("write without idle poll");
    c_nib_write: cover property (nib_r && $fell(enable_strobe)
        && !rw_select_line);
    c_busy_seen: cover property (enable_strobe && !register_select_line
        && rw_select_line && data_line_in[7]);
    c_unmapped: cover property (pready && pslverr);
endmodule

bind cdhp_ctrl cdhp_ctrl_asserts chk_u (.clk_sys(clk_sys), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .register_select_line(register_select_line),
    .rw_select_line(rw_select_line), .enable_strobe(enable_strobe),
    .data_line_in(data_line_in), .data_line_out(data_line_out),
    .data_line_oe(data_line_oe));

// file: verif/cdhp_dev_model.sv
// Behavioural model of the display device behind the parallel port
`timescale 1ns/1ps
module cdhp_dev_model
#(
    parameter int BUSY_CYC = 100    // Internal operation length
)
(
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst,
    // Port pins
    input wire logic       nib,
    input wire logic       rs,
    input wire logic       rw,
    input wire logic       e,
    input wire logic [7:0] din,
    output logic [7:0]     dq
);
    logic [7:0] ram [0:127];    // Display and glyph storage
    logic [7:0] dr;             // Data register
    logic [6:0] ac;             // Address counter
    logic [7:0] by;             // Assembled byte
    logic [7:0] hi;             // First nibble
    logic [7:0] last;           // Last line value
    logic       ph;             // Second nibble pending
    logic       e_d;            // Strobe delayed
    int         bf;             // Busy cycles left
    wire  [6:0] acn = ac + 7'd1;
    // Status or data register
    wire  [7:0] cur = rs ? dr : {bf != 0, ac};
    wire  [7:0] rb  = (nib && ph) ? {cur[3:0], cur[3:0]} : cur;
    // Drive only while strobe is high on reads, else a moving pattern
    assign dq = (e && rw) ? rb : ~last;
    // Capture on strobe fall and run internal operations
    always @(posedge clk_sys or posedge rst)
        if (rst)
        begin
            ac   <= 7'h00;
            dr   <= 8'h00;
            bf   <= 0;
            ph   <= 1'b0;
            e_d  <= 1'b0;
            last <= 8'h00;
        end
        else
        begin
            e_d  <= e;
            last <= dq;
            if (bf != 0)
                bf <= bf - 1;
            if (e_d && !e)
            begin
                ph <= nib ? !ph : 1'b0;
                if (nib && !ph)
                    hi <= din;
                else
                begin
                    by = nib ? {hi[7:4], din[7:4]} : din;
                    // Writes are dropped while busy
                    if (!rw && bf == 0)
                    begin
                        bf <= BUSY_CYC;
                        if (!rs && by[7])
                        begin
                            ac <= by[6:0];
                            dr <= ram[by[6:0]];
                        end
                        else if (rs)
                        begin
                            ram[ac] <= by;
                            ac <= acn;
                        end
                    end
                    else if (rw && rs)
                    begin
                        ac <= acn;
                        dr <= ram[acn];
                    end
                end
            end
        end
endmodule

// file: verif/cdhp_ctrl_test.sv
// Self-checking testbench for the display port host controller
`timescale 1ns/1ps
`include "cdhp_regs.vh"
module cdhp_ctrl_test;
    logic        clk_sys = 0;
    logic        rst = 1;
    logic        psel = 0;
    logic        penable = 0;
    logic        pwrite = 0;
    logic        nib = 0;           // Mode seen by the device
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] seed = 32'h9ea5_71d9;
    logic [32:0] exp_q [$];         // Expected {pslverr, prdata}
    logic [32:0] msk_q [$];         // Bits that matter
    logic [32:0] ev, mv;
    logic [7:0]  b [3];             // Bytes sent
    logic [6:0]  a;                 // Start address
    int          fail_count = 0;
    int          check_count = 0;
    wire [31:0]  prdata;
    wire         pready, pslverr, irq, rsl, rwl, es;
    wire [7:0]   dlo, dloe, dq, dli;
    // Resolve the shared lines per bit
    assign dli = (dlo & dloe) | (dq & ~dloe);
    cdhp_ctrl dut_u (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .register_select_line(rsl),
        .rw_select_line(rwl), .enable_strobe(es), .data_line_in(dli),
        .data_line_out(dlo), .data_line_oe(dloe));
    cdhp_dev_model dev_u (.clk_sys(clk_sys), .rst(rst), .nib(nib),
        .rs(rsl), .rw(rwl), .e(es), .din(dli), .dq(dq));
    initial forever #5 clk_sys = ~clk_sys;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic bad(input string m);
        $display("BAD %0t %s", $time, m);
        fail_count++;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input [7:0] ad, input [31:0] d);
        int k;
        @(posedge clk_sys);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        for (k = 0; k < 50; k++)
        begin
            @(posedge clk_sys);
            if (pready === 1'b1)
                break;
        end
        if (k == 50)
        begin
            bad("no pready");
            wrap_up();
        end
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rd(input [7:0] ad, input [32:0] e, input [32:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        apb(1'b0, ad, 32'h0000_0000);
    endtask
    task automatic wait_done();
        int k;
        for (k = 0; k < 4000 && irq !== 1'b1; k++)
            @(posedge clk_sys);
        if (k == 4000)
        begin
            bad("no done");
            wrap_up();
        end
    endtask
    // One display order, then clear the event
    task automatic go(input logic r, input logic n, input [7:0] v);
        apb(1'b1, `CDHP_OFF_WDATA, {24'h00_0000, v});
        apb(1'b1, `CDHP_OFF_CTRL, {28'h000_0000, nib, n, r, 1'b1});
        wait_done();
        apb(1'b1, `CDHP_OFF_ISTAT, 32'h0000_0003);
        repeat (2) @(posedge clk_sys);
        check_count++;
        if (irq !== 1'b0)
            bad("irq stuck");
    endtask
    // Compare each read with the oldest note
    always @(posedge clk_sys)
        if (psel && penable && pready && !pwrite)
        begin
            if (exp_q.size() == 0)
                bad("unexpected read");
            else
            begin
                ev = exp_q.pop_front();
                mv = msk_q.pop_front();
                check_count++;
                if ((({pslverr, prdata} ^ ev) & mv) !== 33'h0_0000_0000)
                    bad("read mismatch");
            end
        end
    initial
    begin
        repeat (6) @(posedge clk_sys);
        rst <= 0;
        rd(`CDHP_OFF_CTRL, 33'h0_0000_0000, 33'h1_0000_000E);
        rd(`CDHP_OFF_STAT, 33'h0_0000_0000, 33'h1_007F_0101);
        rd(`CDHP_OFF_ISTAT, 33'h0_0000_0000, 33'h1_0000_0003);
        rd(8'h40, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
        $display("reset and map test done");
        apb(1'b1, `CDHP_OFF_IMASK, 32'h0000_0001);
        for (int m = 0; m < 2; m++)
        begin
            nib <= m[0];
            a = xs() & 32'h0000_003F;
            go(1'b0, 1'b0, {1'b1, a});
            go(1'b0, 1'b1, 8'h00);
            rd(`CDHP_OFF_STAT, {10'h0, a, 8'h01, 8'h00}, 33'h1_007F_0101);
            for (int i = 0; i < 3; i++)
            begin
                b[i] = xs();
                go(1'b1, 1'b0, b[i]);
            end
            go(1'b0, 1'b0, {1'b1, a});
            for (int i = 0; i < 3; i++)
            begin
                go(1'b1, 1'b1, 8'h00);
                rd(`CDHP_OFF_RDATA, {25'h0, b[i]}, 33'h1_0000_00FF);
            end
            go(1'b0, 1'b1, 8'h00);
            rd(`CDHP_OFF_STAT, {10'h0, a + 7'd3, 16'h0}, 33'h1_007F_0101);
            $display("mode %0d transfer test done", m);
        end
        // Start while active is refused; mask hides the line
        apb(1'b1, `CDHP_OFF_CTRL, {28'h000_0000, nib, 3'b101});
        apb(1'b1, `CDHP_OFF_CTRL, {28'h000_0000, nib, 3'b101});
        wait_done();
        rd(`CDHP_OFF_ISTAT, 33'h0_0000_0003, 33'h1_0000_0003);
        apb(1'b1, `CDHP_OFF_IMASK, 32'h0000_0000);
        repeat (2) @(posedge clk_sys);
        check_count++;
        if (irq !== 1'b0)
            bad("masked irq high");
        apb(1'b1, `CDHP_OFF_ISTAT, 32'h0000_0003);
        rd(`CDHP_OFF_ISTAT, 33'h0_0000_0000, 33'h1_0000_0003);
        $display("interrupt test done");
        repeat (4) @(posedge clk_sys);
        wrap_up();
    end
endmodule
